// [core/nv_access_pkg.sv]
// Package of constants and types for the non-volatile data memory controller
package nv_access_pkg;
  // ****************************************
  // Memory geometry
  // ****************************************
  localparam int NV_DEPTH = 64;
  localparam int NV_AW = 6;
  localparam int NV_DW = 8;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] NV_CTRL_OFFSET = 8'h40;
  localparam logic [7:0] BANK_ONE = 8'h01;
  localparam logic [7:0] BANK_ZERO = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [5:0] ADDR_RESET = 6'h00;
  localparam logic [1:0] ADDR_PAD = 2'h0;
  localparam logic [3:0] CTRL_PAD = 4'h0;
  localparam logic [6:0] BANK_PAD = 7'h00;

  // Control and bank select field positions
  localparam int STORE_PERMIT_BIT = 3;
  localparam int STORE_START_BIT = 2;
  localparam int FETCH_PERMIT_BIT = 1;
  localparam int FETCH_START_BIT = 0;
  localparam int BANK_SELECT_BIT = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int WRITE_TICKS_DEFAULT = 16;
  localparam int TIMER_DIV_DEFAULT = 8;
  localparam logic [1:0] FETCH_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    NV_IDLE,
    NV_FETCH,
    NV_STORE
  } nv_state_t;
endpackage : nv_access_pkg

// [core/nv_mem_if.sv]
// Interface between the controller and its storage array
`timescale 1ns/1ns
`default_nettype none
interface nv_mem_if;
  import nv_access_pkg::*;
  logic [NV_AW-1:0] addr;
  logic [NV_DW-1:0] wdata;
  logic we;
  logic [NV_DW-1:0] rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface : nv_mem_if
`default_nettype wire

// [core/nv_store_mem.sv]
// Byte-wide storage array with registered read data
`timescale 1ns/1ns
`default_nettype none
module nv_store_mem (
  // Clock
  input wire logic sys_clk_i,
  // Access port
  nv_mem_if.mem port
);
  import nv_access_pkg::*;

  logic [NV_DW-1:0] cells [NV_DEPTH];

  always_ff @(posedge sys_clk_i) begin
    if (port.we) begin
      cells[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    port.rdata <= cells[port.addr];
  end
endmodule : nv_store_mem
`default_nettype wire

// [core/nv_access_timer.sv]
// Free-running tick source standing in for the write-cycle timer
`timescale 1ns/1ns
`default_nettype none
module nv_access_timer #(
  parameter int DIV = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Tick
  output logic tick_o
);
  import nv_access_pkg::*;

  logic [15:0] div_reg;

  // Its phase is unrelated to any register access
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      div_reg <= 16'h0000;
      tick_o <= 1'b0;
    end else if (div_reg == 16'(DIV - 1)) begin
      div_reg <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      div_reg <= div_reg + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule : nv_access_timer
`default_nettype wire

// [core/nv_data_access_ctrl.sv]
// Byte access controller for the 64-byte non-volatile data memory
`timescale 1ns/1ns
`default_nettype none
module nv_data_access_ctrl #(
  parameter int WRITE_TICKS = nv_access_pkg::WRITE_TICKS_DEFAULT,
  parameter int TIMER_DIV = nv_access_pkg::TIMER_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Direct special register access (bank zero)
  input wire logic addr_we_i,
  input wire logic data_we_i,
  input wire logic [7:0] wdata_i,
  // Bank select register
  input wire logic bank_we_i,
  // Indirect access through pointer one
  input wire logic [7:0] indirect_pointer_one_i,
  input wire logic indirect_access_port_one_we_i,
  // Interrupt handshake
  input wire logic nv_done_irq_ack_i,
  // Read-back
  output logic [7:0] nv_addr_reg_o,
  output logic [7:0] nv_data_reg_o,
  output logic [7:0] nv_ctrl_reg_o,
  output logic [7:0] bank_select_o,
  output logic nv_done_irq_flag_o
);
  import nv_access_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [NV_AW-1:0] nv_addr_reg;
  logic [NV_DW-1:0] nv_data_reg;
  logic store_permit_reg;
  logic store_start_reg;
  logic fetch_permit_reg;
  logic fetch_start_reg;
  logic bank_select_reg;
  logic nv_done_irq_flag_reg;
  nv_state_t state_reg;
  logic [15:0] tick_cnt_reg;
  logic [1:0] fetch_cnt_reg;
  logic tick;

  nv_mem_if mem_bus ();

  nv_store_mem u_mem (
    .sys_clk_i(sys_clk_i),
    .port(mem_bus.mem)
  );

  nv_access_timer #(.DIV(TIMER_DIV)) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .tick_o(tick)
  );

  // ****************************************
  // Control register decode
  // ****************************************
  logic ctrl_we;
  logic req_store;
  logic req_fetch;
  logic store_done;
  logic fetch_done;

  assign ctrl_we = indirect_access_port_one_we_i && bank_select_reg &&
                   (indirect_pointer_one_i == NV_CTRL_OFFSET);
  // Permit must already be set before this write
  // Both starts in one write cancel each other
  assign req_store = ctrl_we && wdata_i[STORE_START_BIT] && store_permit_reg &&
                     !wdata_i[FETCH_START_BIT] && (state_reg == NV_IDLE);
  assign req_fetch = ctrl_we && wdata_i[FETCH_START_BIT] && fetch_permit_reg &&
                     !wdata_i[STORE_START_BIT] && (state_reg == NV_IDLE);
  assign store_done = (state_reg == NV_STORE) && tick &&
                      (tick_cnt_reg == 16'(WRITE_TICKS - 1));
  assign fetch_done = (state_reg == NV_FETCH) && (fetch_cnt_reg == FETCH_CYCLES);

  // Memory port: address from the register, write only at cycle end
  assign mem_bus.addr = nv_addr_reg;
  assign mem_bus.wdata = nv_data_reg;
  assign mem_bus.we = store_done;

  // ****************************************
  // Sequencer
  // ****************************************
  // A running cycle ignores any further start request
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_reg <= NV_IDLE;
    end else begin
      case (state_reg)
        NV_IDLE: begin
          if (req_store) begin
            state_reg <= NV_STORE;
          end else if (req_fetch) begin
            state_reg <= NV_FETCH;
          end
        end
        NV_FETCH: begin
          if (fetch_done) begin
            state_reg <= NV_IDLE;
          end
        end
        NV_STORE: begin
          if (store_done) begin
            state_reg <= NV_IDLE;
          end
        end
        default: begin
          state_reg <= NV_IDLE;
        end
      endcase
    end
  end

  // Write length counted in timer ticks
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      tick_cnt_reg <= 16'h0000;
    end else if (state_reg != NV_STORE) begin
      tick_cnt_reg <= 16'h0000;
    end else if (tick) begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // Read stays in NV_FETCH for three cycles before taking the registered memory data
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fetch_cnt_reg <= 2'h0;
    end else if (state_reg != NV_FETCH) begin
      fetch_cnt_reg <= 2'h0;
    end else begin
      fetch_cnt_reg <= fetch_cnt_reg + 2'h1;
    end
  end

  // ****************************************
  // Address and data registers
  // ****************************************
  // Address has no defined reset; zero chosen for determinism
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      nv_addr_reg <= ADDR_RESET;
    end else if (addr_we_i && state_reg == NV_IDLE) begin
      nv_addr_reg <= wdata_i[NV_AW-1:0];
    end
  end

  // Held during a cycle so the store sees stable data
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      nv_data_reg <= DATA_RESET;
    end else if (fetch_done) begin
      nv_data_reg <= mem_bus.rdata;
    end else if (data_we_i && state_reg == NV_IDLE) begin
      nv_data_reg <= wdata_i;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      store_permit_reg <= 1'b0;
    end else if (ctrl_we) begin
      store_permit_reg <= wdata_i[STORE_PERMIT_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fetch_permit_reg <= 1'b0;
    end else if (ctrl_we) begin
      fetch_permit_reg <= wdata_i[FETCH_PERMIT_BIT];
    end
  end

  // Start bits are set only by accepted requests; software cannot clear mid-cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      store_start_reg <= 1'b0;
    end else if (req_store) begin
      store_start_reg <= 1'b1;
    end else if (store_done) begin
      store_start_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fetch_start_reg <= 1'b0;
    end else if (req_fetch) begin
      fetch_start_reg <= 1'b1;
    end else if (fetch_done) begin
      fetch_start_reg <= 1'b0;
    end
  end

  // ****************************************
  // Bank select and done flag
  // ****************************************
  // Bank one is the only route to the control register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      bank_select_reg <= 1'b0;
    end else if (bank_we_i) begin
      bank_select_reg <= wdata_i[BANK_SELECT_BIT];
    end
  end

  // Set wins over the service clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      nv_done_irq_flag_reg <= 1'b0;
    end else if (store_done) begin
      nv_done_irq_flag_reg <= 1'b1;
    end else if (nv_done_irq_ack_i) begin
      nv_done_irq_flag_reg <= 1'b0;
    end
  end

  // ****************************************
  // Read-back outputs
  // ****************************************
  logic [7:0] ctrl_view;
  assign ctrl_view = {CTRL_PAD, store_permit_reg, store_start_reg,
                      fetch_permit_reg, fetch_start_reg};

  // Registered read-back: software sees every change one edge late
  // One flop group per register keeps each reset value local
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      nv_addr_reg_o <= {ADDR_PAD, ADDR_RESET};
    end else begin
      nv_addr_reg_o <= {ADDR_PAD, nv_addr_reg};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      nv_data_reg_o <= DATA_RESET;
    end else begin
      nv_data_reg_o <= nv_data_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      nv_ctrl_reg_o <= {CTRL_PAD, CTRL_RESET};
    end else begin
      nv_ctrl_reg_o <= ctrl_view;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      bank_select_o <= BANK_ZERO;
    end else begin
      bank_select_o <= {BANK_PAD, bank_select_reg};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      nv_done_irq_flag_o <= 1'b0;
    end else begin
      nv_done_irq_flag_o <= nv_done_irq_flag_reg;
    end
  end
endmodule : nv_data_access_ctrl
`default_nettype wire

// [testbench/nv_access_properties.sv]
// Port-level checks for the non-volatile data access controller
`timescale 1ns/1ns
`default_nettype none
module nv_access_properties #(
  parameter int WRITE_TICKS = 16,
  parameter int TIMER_DIV = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Requests
  input wire logic data_we_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] indirect_pointer_one_i,
  input wire logic indirect_access_port_one_we_i,
  input wire logic nv_done_irq_ack_i,
  // Read-back
  input wire logic [7:0] nv_addr_reg_o,
  input wire logic [7:0] nv_data_reg_o,
  input wire logic [7:0] nv_ctrl_reg_o,
  input wire logic [7:0] bank_select_o,
  input wire logic nv_done_irq_flag_o
);
  // Timer phase is free, so one edge of slack each side
  localparam int LO = (WRITE_TICKS - 1) * TIMER_DIV;
  localparam int HI = WRITE_TICKS * TIMER_DIV + 1;
  logic cw;
  logic idle;
  // Read-back lags one edge: valid only with a quiet edge between writes
  assign cw = indirect_access_port_one_we_i && indirect_pointer_one_i == 8'h40 && bank_select_o[0];
  assign idle = !nv_ctrl_reg_o[2] && !nv_ctrl_reg_o[0];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_pad_bits_zero: assert property (
    nv_addr_reg_o[7:6] == 2'h0 && nv_ctrl_reg_o[7:4] == 4'h0 && bank_select_o[7:1] == 7'h00)
    else $error("pad bits not zero");
  a_reset_values: assert property ($rose(rst_b_i) |-> nv_ctrl_reg_o == 8'h00 &&
    nv_data_reg_o == 8'h00 && bank_select_o == 8'h00 && !nv_done_irq_flag_o)
    else $error("outputs not cleared by reset");
  a_fetch_timing: assert property (
    cw && wdata_i[2:0] == 3'h3 && nv_ctrl_reg_o[1] && idle
    |-> ##2 nv_ctrl_reg_o[0] [*3] ##1 !nv_ctrl_reg_o[0]) else $error("fetch timing wrong");
  a_fetch_refused: assert property (
    cw && wdata_i[0] && (!nv_ctrl_reg_o[1] || wdata_i[2])
    && idle |-> ##2 !nv_ctrl_reg_o[0]) else $error("refused fetch started");
  a_store_refused: assert property (
    cw && wdata_i[2] && (!nv_ctrl_reg_o[3] || wdata_i[0])
    && idle |-> ##2 !nv_ctrl_reg_o[2]) else $error("refused store started");
  a_store_starts: assert property (
    cw && wdata_i[3:2] == 2'h3 && !wdata_i[0] && nv_ctrl_reg_o[3]
    && idle |-> ##2 nv_ctrl_reg_o[2]) else $error("store did not start");
  a_store_length: assert property (
    $rose(nv_ctrl_reg_o[2]) |-> ##[LO:HI] $fell(nv_ctrl_reg_o[2]))
    else $error("store length out of window");
  a_done_flag_set: assert property ($fell(nv_ctrl_reg_o[2]) |-> ##[0:1] nv_done_irq_flag_o)
    else $error("done flag not raised");
  a_ack_clears_flag: assert property (nv_done_irq_flag_o && nv_done_irq_ack_i &&
    !nv_ctrl_reg_o[2] |-> ##2 !nv_done_irq_flag_o) else $error("done flag not cleared");
  a_data_holds: assert property ($changed(nv_data_reg_o) |->
    $past(data_we_i, 2) || $past(nv_ctrl_reg_o[0])) else $error("data register changed alone");
  c_fetch_done: cover property ($fell(nv_ctrl_reg_o[0]));
  c_store_done: cover property ($rose(nv_done_irq_flag_o));
  c_flag_acked: cover property ($fell(nv_done_irq_flag_o));
endmodule : nv_access_properties
`default_nettype wire

// [testbench/test_nv_data_access_ctrl.sv]
// Self-checking bench for the non-volatile data access controller
`timescale 1ns/1ns
`default_nettype none
module test_nv_data_access_ctrl;
  import nv_access_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic addr_we_i = 1'b0;
  logic data_we_i = 1'b0;
  logic bank_we_i = 1'b0;
  logic indirect_access_port_one_we_i = 1'b0;
  logic nv_done_irq_ack_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] indirect_pointer_one_i = 8'h40;
  logic [7:0] nv_addr_reg_o, nv_data_reg_o, nv_ctrl_reg_o, bank_select_o;
  logic nv_done_irq_flag_o;
  int errors = 0;
  int n_compared = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  // Short write so the run stays brief
  nv_data_access_ctrl #(.WRITE_TICKS(2), .TIMER_DIV(2)) u_nv_data_access_ctrl (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .addr_we_i(addr_we_i),
    .data_we_i(data_we_i),
    .wdata_i(wdata_i),
    .bank_we_i(bank_we_i),
    .indirect_pointer_one_i(indirect_pointer_one_i),
    .indirect_access_port_one_we_i(indirect_access_port_one_we_i),
    .nv_done_irq_ack_i(nv_done_irq_ack_i),
    .nv_addr_reg_o(nv_addr_reg_o),
    .nv_data_reg_o(nv_data_reg_o),
    .nv_ctrl_reg_o(nv_ctrl_reg_o),
    .bank_select_o(bank_select_o),
    .nv_done_irq_flag_o(nv_done_irq_flag_o)
  );
  // ****
  // Helpers
  // ****
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One strobe edge, then a quiet edge so the lagging read-back settles
  task automatic put(input int sel, input logic [7:0] v);
    wdata_i = v;
    {addr_we_i, data_we_i, bank_we_i, indirect_access_port_one_we_i} = 4'h8 >> sel;
    tick();
    {addr_we_i, data_we_i, bank_we_i, indirect_access_port_one_we_i} = 4'h0;
    tick();
  endtask : put
  task automatic wait_clr(input int b);
    int i;
    for (i = 0; i < 100 && nv_ctrl_reg_o[b] !== 1'b0; i++) tick();
    if (i == 100) chk(8'h01, 8'h00);
  endtask : wait_clr
  task automatic close_out();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    chk(nv_ctrl_reg_o, 8'h00);
    chk(nv_data_reg_o, DATA_RESET);
    chk({bank_select_o[6:0], nv_done_irq_flag_o}, 8'h00);
    put(0, 8'hff);
    chk(nv_addr_reg_o, 8'h3f);
    put(1, 8'ha5);
    chk(nv_data_reg_o, 8'ha5);
    put(3, 8'h0a);
    chk(nv_ctrl_reg_o, 8'h00);
    put(2, 8'hff);
    chk(bank_select_o, 8'h01);
    indirect_pointer_one_i = 8'h41;
    put(3, 8'h0a);
    chk(nv_ctrl_reg_o, 8'h00);
    indirect_pointer_one_i = 8'h40;
    put(3, 8'hfa);
    chk(nv_ctrl_reg_o, 8'h0a);
  endtask : t_regs
  task automatic t_refuse();
    put(3, 8'h00);
    put(3, 8'h04);
    chk(nv_ctrl_reg_o, 8'h00);
    put(3, 8'h0c);
    chk(nv_ctrl_reg_o, 8'h08);
    put(3, 8'h03);
    chk(nv_ctrl_reg_o, 8'h02);
    put(3, 8'h0a);
    put(3, 8'h0f);
    chk(nv_ctrl_reg_o, 8'h0a);
    repeat (3) tick();
    chk(nv_data_reg_o, 8'ha5);
  endtask : t_refuse
  task automatic t_store(input logic [5:0] a, input logic [7:0] d);
    put(3, 8'h08);
    put(0, {2'h0, a});
    put(1, d);
    put(3, 8'h08);
    put(3, 8'h0c);
    chk(nv_ctrl_reg_o, 8'h0c);
    wait_clr(2);
    tick();
    chk({7'h00, nv_done_irq_flag_o}, 8'h01);
    nv_done_irq_ack_i = 1'b1;
    tick();
    nv_done_irq_ack_i = 1'b0;
    tick();
    chk({7'h00, nv_done_irq_flag_o}, 8'h00);
    put(3, 8'h00);
  endtask : t_store
  task automatic t_fetch(input logic [5:0] a, input logic [7:0] d);
    put(3, 8'h02);
    put(0, {2'h0, a});
    put(3, 8'h03);
    wait_clr(0);
    chk(nv_data_reg_o, d);
    put(0, {2'h0, ~a});
    put(3, 8'h00);
    put(3, 8'h01);
    repeat (3) tick();
    chk(nv_ctrl_reg_o, 8'h00);
    chk(nv_data_reg_o, d);
  endtask : t_fetch
  task automatic t_no_permit();
    put(3, 8'h04);
    chk(nv_ctrl_reg_o, 8'h00);
    t_fetch(6'h3f, 8'h5a);
  endtask : t_no_permit
  task automatic t_reset();
    put(3, 8'h0a);
    rst_b_i = 1'b0;
    repeat (2) tick();
    rst_b_i = 1'b1;
    chk(bank_select_o, BANK_ZERO);
    chk(nv_ctrl_reg_o, 8'h00);
    chk(nv_data_reg_o, DATA_RESET);
    put(3, 8'h0a);
    chk(nv_ctrl_reg_o, 8'h00);
  endtask : t_reset
  initial begin
    repeat (16) tick();
    rst_b_i = 1'b1;
    t_regs();
    t_refuse();
    t_store(6'h00, 8'hc3);
    t_store(6'h3f, 8'h5a);
    t_fetch(6'h3f, 8'h5a);
    t_fetch(6'h00, 8'hc3);
    t_no_permit();
    t_reset();
    close_out();
  end
  initial begin
    #100000;
    errors++;
    close_out();
  end
endmodule : test_nv_data_access_ctrl
bind nv_data_access_ctrl nv_access_properties #(
  .WRITE_TICKS(WRITE_TICKS),
  .TIMER_DIV(TIMER_DIV)
) u_nv_access_properties (
  .sys_clk_i(sys_clk_i),
  .rst_b_i(rst_b_i),
  .data_we_i(data_we_i),
  .wdata_i(wdata_i),
  .indirect_pointer_one_i(indirect_pointer_one_i),
  .indirect_access_port_one_we_i(indirect_access_port_one_we_i),
  .nv_done_irq_ack_i(nv_done_irq_ack_i),
  .nv_addr_reg_o(nv_addr_reg_o),
  .nv_data_reg_o(nv_data_reg_o),
  .nv_ctrl_reg_o(nv_ctrl_reg_o),
  .bank_select_o(bank_select_o),
  .nv_done_irq_flag_o(nv_done_irq_flag_o)
);
`default_nettype wire
